// ---- fbu_consts.svh ----
// Offsets, reset values and widths for the fetch bus unit
`ifndef FBU_CONSTS_SVH
`define FBU_CONSTS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FBU_OFF_CTRL 5'h00
`define FBU_OFF_CS 5'h04
`define FBU_OFF_DS 5'h08
`define FBU_OFF_SS 5'h0C
`define FBU_OFF_ES 5'h10
`define FBU_OFF_IP 5'h14
`define FBU_OFF_STAT 5'h18
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define FBU_CTRL_IE_BIT 0
`define FBU_RST_CS 16'hFFFF
`define FBU_RST_IP 16'h0000
`define FBU_RST_SEG 16'h0000
`define FBU_Q_DEPTH 3'h4
`define FBU_SEG_SHIFT 4'h0
`endif

// ---- fbu_mem_model.sv ----
// Memory and I/O model on the far side of the fetch bus unit
module fbu_mem_model (
	input wire logic clock_i,
	input wire logic slow_i,
	input wire logic ale_i,
	input wire logic den_n_i,
	input wire logic dir_i,
	input wire logic oe_n_i,
	input wire logic [2:0] kind_i,
	input wire logic [7:0] ad_i,
	input wire logic [7:0] mid_i,
	input wire logic [3:0] high_i,
	output logic [7:0] ad_o,
	output logic ready_o,
	output logic [19:0] addr_o,
	output logic [2:0] kind_o,
	output logic [3:0] stat_o,
	output logic [7:0] wbyte_o,
	output logic [7:0] span_o,
	output logic [15:0] cycles_o
);
	logic [7:0] cnt;
	logic armed;
	logic [2:0] kprev;
	logic strobe;
	logic incyc;
	// Maximum mode has no strobe pin: decode it from status as a bus controller would
	assign strobe = ale_i || (kind_i != 3'h7 && kprev == 3'h7);
	assign incyc = (kind_i != 3'h7) && !strobe;
	initial begin
		kprev = 3'h7;
		ad_o = 8'h00;
		ready_o = 1'h1;
		span_o = 8'h00;
		cycles_o = 16'h0000;
		cnt = 8'h00;
		armed = 1'h0;
	end
	// ----------------------------------------
	// Bus response
	// ----------------------------------------
	always @(posedge clock_i) begin
		kprev <= kind_i;
		if (strobe) begin
			addr_o <= {high_i, mid_i, ad_i};
			kind_o <= kind_i;
			cycles_o <= cycles_o + 16'h0001;
		end
		if (cnt == 8'h01)
			stat_o <= high_i;
		if (armed && den_n_i && cnt > 8'h01 && cnt > span_o)
			span_o <= cnt;
		if (strobe) begin
			cnt <= 8'h01;
			armed <= 1'h1;
		end else if (den_n_i && cnt > 8'h01)
			armed <= 1'h0;
		else if (armed)
			cnt <= cnt + 8'h01;
		// Released bus toggles, so stale data never passes
		ad_o <= (incyc && !kind_i[1] && oe_n_i && !dir_i) ? addr_o[7:0] ^ {addr_o[19:16], addr_o[11:8]} : ~ad_o;
		if (!oe_n_i && dir_i && !den_n_i)
			wbyte_o <= ad_i;
		// Slow device answers ready only as a short late pulse
		ready_o <= !slow_i || (armed && (cnt == 8'h04 || cnt == 8'h05));
	end
endmodule : fbu_mem_model

// ---- fbu_pkg.sv ----
// Types shared by the fetch bus unit
package fbu_pkg;
	typedef enum logic [2:0] {
		PH_TI = 3'b000,
		PH_T1 = 3'b001,
		PH_T2 = 3'b010,
		PH_T3 = 3'b011,
		PH_TW = 3'b100,
		PH_T4 = 3'b101
	} fbu_phase_t;
	typedef enum logic [2:0] {
		K_INTA = 3'b000,
		K_IORD = 3'b001,
		K_IOWR = 3'b010,
		K_HALT = 3'b011,
		K_FETCH = 3'b100,
		K_MRD = 3'b101,
		K_MWR = 3'b110,
		K_PASS = 3'b111
	} fbu_kind_t;
	typedef enum logic [1:0] {
		SEG_ES = 2'b00,
		SEG_SS = 2'b01,
		SEG_CS = 2'b10,
		SEG_DS = 2'b11
	} fbu_seg_t;
	typedef enum logic [1:0] {
		SC_DATA = 2'b00,
		SC_STACK = 2'b01,
		SC_STRDST = 2'b10,
		SC_CODE = 2'b11
	} fbu_class_t;
	typedef struct packed {
		fbu_phase_t ph;
		fbu_kind_t kind;
		fbu_seg_t seg;
		logic [19:0] addr;
		logic [7:0] wbyte;
		logic [15:0] cs;
		logic [15:0] ds;
		logic [15:0] ss;
		logic [15:0] es;
		logic [15:0] ip;
		logic [3:0][7:0] qmem;
		logic [1:0] qrd;
		logic [2:0] qcnt;
		logic drop;
		logic ie;
		logic opbusy;
		logic opvec;
		fbu_kind_t opkind;
		fbu_seg_t opseg;
		logic [15:0] opoff;
		logic [15:0] opwdata;
		logic [31:0] oprdata;
		logic [1:0] opbyte;
		logic [1:0] oplast;
		logic opdone;
		logic halted;
		logic [1:0] qs;
		logic av_ack;
		logic [31:0] rdata;
		logic r1;
		logic r2;
		logic r3;
		logic rdy;
		logic m1;
		logic m2;
		logic m3;
		logic mode;
	} fbu_state_t;
endpackage : fbu_pkg

// ---- fbu_top.sv ----
// Fetch bus unit: prefetch queue, address relocation and local bus cycles
// Contract
// - All state sits in clocked flops; clock may stop or step freely.
// - Prefetch queue holds at most four instruction bytes.
// - With room for one byte, start a one-byte fetch cycle.
// - Queue is first-in first-out; a byte into an empty queue shows at once.
// - Every memory reference drives a 20-bit byte address.
// - Segments start on 16-byte bounds; references use one of four bases.
// - Code for prefetch, stack for stack/BP, data default, extra for string dest.
// - Words go low byte first as two consecutive byte cycles.
// - After reset, fetching starts at sixteen bytes below top of memory.
// - Vector table at bottom: offset to pointer, then segment to code base.
// - Strap low gives maximum mode, strap high gives minimum mode.
// - Minimum mode drives transceiver enable, direction and address strobe.
// - Maximum mode gives lock, queue status and request/grant pins; request/grant is held idle high and never driven.
// - Low byte shares address/data, top nibble address/status, middle stays stable.
// - Bus cycle is at least four clocks: address, turnaround, data, data.
// - Not ready inserts one-clock wait phases between third and fourth clock.
// - Idle phases between cycles drive no transfer.
// - Address strobe pulses in the first clock of each cycle.
// - Cycle type code: 000 inta..111 passive as tabled.
// - Extra status bits sit on the top lines from second to fourth clock.
// - Segment status: 00 extra, 01 stack, 10 code or none, 11 data.
// - Fifth status bit mirrors interrupt enable; sixth is always zero.
// - I/O cycles put the port on the low sixteen lines, top four zero.
// - Queue status valid the clock after the operation, never floats.
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`include "fbu_consts.svh"
module fbu_top (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic config_strap_i,
	input wire logic ready_i,
	input wire logic [7:0] low_addr_data_i,
	output logic [7:0] low_addr_data_o,
	output logic low_addr_data_oe_n_o,
	output logic [7:0] mid_addr_o,
	output logic [3:0] high_addr_status_o,
	output logic ale_o,
	output logic xcvr_enable_n_o,
	output logic xfer_direction_o,
	output fbu_pkg::fbu_kind_t cycle_type_o,
	output logic lock_n_o,
	output logic [1:0] queue_state_out_o,
	output logic [1:0] rq_gt_o,
	output logic [1:0] rq_gt_oe_n_o,
	output logic [7:0] q_byte_o,
	output logic q_valid_o,
	input wire logic q_take_i,
	input wire logic q_first_i,
	input wire logic eu_flush_i,
	input wire logic [15:0] eu_jump_cs_i,
	input wire logic [15:0] eu_jump_ip_i,
	input wire logic eu_lock_i,
	input wire logic halt_req_i,
	input wire logic op_req_i,
	input wire logic op_write_i,
	input wire logic op_io_i,
	input wire logic op_word_i,
	input wire fbu_pkg::fbu_class_t op_class_i,
	input wire logic op_override_i,
	input wire fbu_pkg::fbu_seg_t op_override_seg_i,
	input wire logic [15:0] op_offset_i,
	input wire logic [15:0] op_wdata_i,
	input wire logic vec_req_i,
	input wire logic [7:0] vec_type_i,
	output logic op_ready_o,
	output logic op_done_o,
	output logic [15:0] op_rdata_o
);
	import fbu_pkg::*;

	fbu_state_t s;
	fbu_state_t next_s;
	logic flush;
	logic [15:0] boff;
	logic [15:0] base;
	logic is_wr;
	logic act;
	logic t1;

	// ----------------------------------------
	// Relocation
	// ----------------------------------------
	function automatic logic [15:0] seg_base(input fbu_state_t st, input fbu_seg_t sg);
		case (sg)
			SEG_ES: seg_base = st.es;
			SEG_SS: seg_base = st.ss;
			SEG_DS: seg_base = st.ds;
			default: seg_base = st.cs;
		endcase
	endfunction : seg_base

	function automatic logic [19:0] phys(input logic [15:0] b, input logic [15:0] off);
		logic [20:0] sum;
		sum = {1'b0, b, `FBU_SEG_SHIFT} + {5'h00, off};
		phys = sum[19:0];
	endfunction : phys

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_s = s;
		boff = 16'h0000;
		base = 16'h0000;
		next_s.opdone = 1'b0;
		next_s.qs = 2'b00;
		// Pins pass three flops; a change counts when the last two agree
		next_s.r1 = ready_i;
		next_s.r2 = s.r1;
		next_s.r3 = s.r2;
		if (s.r2 == s.r3)
			next_s.rdy = s.r3;
		next_s.m1 = config_strap_i;
		next_s.m2 = s.m1;
		next_s.m3 = s.m2;
		if (s.m2 == s.m3)
			next_s.mode = s.m3;
		// Register slave: one wait cycle, write lands on the released edge
		next_s.av_ack = (avs_read_i | avs_write_i) & ~s.av_ack;
		if (avs_read_i & ~s.av_ack) begin
			case (avs_address_i)
				`FBU_OFF_CTRL: next_s.rdata = {31'h00000000, s.ie};
				`FBU_OFF_CS: next_s.rdata = {16'h0000, s.cs};
				`FBU_OFF_DS: next_s.rdata = {16'h0000, s.ds};
				`FBU_OFF_SS: next_s.rdata = {16'h0000, s.ss};
				`FBU_OFF_ES: next_s.rdata = {16'h0000, s.es};
				`FBU_OFF_IP: next_s.rdata = {16'h0000, s.ip};
				`FBU_OFF_STAT: next_s.rdata = {22'h000000, s.halted, s.mode, 1'b0, s.ph, 1'b0, s.qcnt};
				default: next_s.rdata = 32'h00000000;
			endcase
		end
		flush = eu_flush_i;
		if (avs_write_i & s.av_ack) begin
			case (avs_address_i)
				`FBU_OFF_CTRL: next_s.ie = avs_writedata_i[`FBU_CTRL_IE_BIT];
				`FBU_OFF_DS: next_s.ds = avs_writedata_i[15:0];
				`FBU_OFF_SS: next_s.ss = avs_writedata_i[15:0];
				`FBU_OFF_ES: next_s.es = avs_writedata_i[15:0];
				`FBU_OFF_CS: begin
					next_s.cs = avs_writedata_i[15:0];
					flush = 1'b1;
				end
				`FBU_OFF_IP: begin
					next_s.ip = avs_writedata_i[15:0];
					flush = 1'b1;
				end
				default: ;
			endcase
		end
		// Jump: old bytes and any fetch still on the bus are thrown away
		if (eu_flush_i) begin
			next_s.cs = eu_jump_cs_i;
			next_s.ip = eu_jump_ip_i;
		end
		if (flush) begin
			next_s.qcnt = 3'h0;
			next_s.qrd = 2'h0;
			next_s.qs = 2'b10;
			next_s.drop = (s.ph != PH_TI) && (s.ph != PH_T4) && (s.kind == K_FETCH);
		end else if (q_take_i && s.qcnt != 3'h0) begin
			next_s.qrd = s.qrd + 2'h1;
			next_s.qcnt = s.qcnt - 3'h1;
			next_s.qs = q_first_i ? 2'b01 : 2'b11;
		end
		// Operand and vector requests wait in one slot
		if (!s.opbusy && vec_req_i) begin
			next_s.opbusy = 1'b1;
			next_s.opvec = 1'b1;
			next_s.opkind = K_MRD;
			next_s.opseg = SEG_CS;
			next_s.opoff = {6'h00, vec_type_i, 2'b00};
			next_s.opbyte = 2'h0;
			next_s.oplast = 2'h3;
		end else if (!s.opbusy && op_req_i) begin
			next_s.opbusy = 1'b1;
			next_s.opvec = 1'b0;
			next_s.opwdata = op_wdata_i;
			next_s.opoff = op_offset_i;
			next_s.opbyte = 2'h0;
			next_s.oplast = op_word_i ? 2'h1 : 2'h0;
			if (op_io_i)
				next_s.opkind = op_write_i ? K_IOWR : K_IORD;
			else
				next_s.opkind = op_write_i ? K_MWR : K_MRD;
			// String destination keeps extra, code keeps code; override steers stack and data
			case (op_class_i)
				SC_STRDST: next_s.opseg = SEG_ES;
				SC_CODE: next_s.opseg = SEG_CS;
				SC_STACK: next_s.opseg = op_override_i ? op_override_seg_i : SEG_SS;
				default: next_s.opseg = op_override_i ? op_override_seg_i : SEG_DS;
			endcase
			if (op_io_i)
				next_s.opseg = SEG_CS;
		end
		if (!halt_req_i)
			next_s.halted = 1'b0;
		// ----------------------------------------
		// Bus phase sequencer
		// ----------------------------------------
		case (s.ph)
			PH_T1: next_s.ph = PH_T2;
			PH_T2: next_s.ph = PH_T3;
			PH_T3, PH_TW: begin
				if (!s.rdy) begin
					next_s.ph = PH_TW;
				end else begin
					next_s.ph = PH_T4;
					case (s.kind)
						K_FETCH: begin
							if (!s.drop && !flush) begin
								next_s.qmem[next_s.qrd + next_s.qcnt[1:0]] = low_addr_data_i;
								next_s.qcnt = next_s.qcnt + 3'h1;
								next_s.ip = s.ip + 16'h0001;
							end
							next_s.drop = 1'b0;
						end
						K_HALT: next_s.halted = 1'b1;
						default: begin
							if (s.kind == K_MRD || s.kind == K_IORD)
								next_s.oprdata[{s.opbyte, 3'b000} +: 8] = low_addr_data_i;
							next_s.opbyte = s.opbyte + 2'h1;
							if (s.opbyte == s.oplast) begin
								next_s.opbusy = 1'b0;
								next_s.opdone = 1'b1;
								if (s.opvec && !eu_flush_i) begin
									next_s.ip = s.oprdata[15:0];
									next_s.cs = {low_addr_data_i, s.oprdata[23:16]};
									next_s.qcnt = 3'h0;
									next_s.qrd = 2'h0;
									next_s.qs = 2'b10;
								end
							end
						end
					endcase
				end
			end
			default: begin
				// T4 or idle: pick the next cycle, operands before prefetch
				next_s.ph = PH_TI;
				next_s.kind = K_PASS;
				if (s.opbusy && !flush) begin
					next_s.ph = PH_T1;
					next_s.kind = s.opkind;
					next_s.seg = s.opseg;
					boff = s.opoff + {14'h0000, s.opbyte};
					base = s.opvec ? 16'h0000 : seg_base(s, s.opseg);
					next_s.addr = phys(base, boff);
					if (s.opkind == K_IORD || s.opkind == K_IOWR)
						next_s.addr = {4'h0, boff};
					next_s.wbyte = s.opwdata[{s.opbyte[0], 3'b000} +: 8];
				end else if (halt_req_i && !s.halted && !flush) begin
					next_s.ph = PH_T1;
					next_s.kind = K_HALT;
					next_s.seg = SEG_CS;
				end else if (!s.halted && next_s.qcnt < `FBU_Q_DEPTH) begin
					next_s.ph = PH_T1;
					next_s.kind = K_FETCH;
					next_s.seg = SEG_CS;
					next_s.addr = phys(next_s.cs, next_s.ip);
				end
			end
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	// Plain edge-triggered flops only, so a stopped clock loses nothing
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			s <= '0;
			s.ph <= PH_TI;
			s.kind <= K_PASS;
			s.seg <= SEG_CS;
			s.cs <= `FBU_RST_CS;
			s.ip <= `FBU_RST_IP;
			s.ds <= `FBU_RST_SEG;
			s.ss <= `FBU_RST_SEG;
			s.es <= `FBU_RST_SEG;
			s.opkind <= K_PASS;
			s.opseg <= SEG_CS;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Pins
	// ----------------------------------------
	assign t1 = (s.ph == PH_T1);
	assign act = (s.ph != PH_TI);
	assign is_wr = (s.kind == K_MWR) || (s.kind == K_IOWR);
	assign low_addr_data_o = t1 ? s.addr[7:0] : s.wbyte;
	assign low_addr_data_oe_n_o = ~(t1 || (is_wr && act));
	assign mid_addr_o = s.addr[15:8];
	// Top nibble: address in T1, then status; zero when idle
	assign high_addr_status_o = t1 ? s.addr[19:16] : (act ? {1'b0, s.ie, s.seg} : 4'h0);
	assign ale_o = t1 & s.mode;
	assign xcvr_enable_n_o = ~(s.mode && act && !t1);
	assign xfer_direction_o = s.mode & act & is_wr;
	assign cycle_type_o = (act && s.ph != PH_T4) ? s.kind : K_PASS;
	assign lock_n_o = s.mode | ~eu_lock_i;
	assign queue_state_out_o = s.mode ? 2'b00 : s.qs;
	// Request/grant lines idle high and are never driven by this unit
	assign rq_gt_o = 2'b11;
	assign rq_gt_oe_n_o = 2'b11;
	assign q_byte_o = s.qmem[s.qrd];
	assign q_valid_o = (s.qcnt != 3'h0);
	assign op_ready_o = ~s.opbusy;
	assign op_done_o = s.opdone;
	assign op_rdata_o = s.oprdata[15:0];
	assign avs_readdata_o = s.rdata;
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~s.av_ack;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	a_queue_bound: assert property (s.qcnt <= `FBU_Q_DEPTH)
		else $error("queue over four bytes");
	a_four_clocks: assert property (s.ph == PH_T1 |=> s.ph == PH_T2 ##1 s.ph == PH_T3)
		else $error("cycle shorter than T1 T2 T3");
	a_wait_state: assert property ((s.ph inside {PH_T3, PH_TW}) && !s.rdy |=> s.ph == PH_TW)
		else $error("not ready did not insert wait");
	a_strobe_t1: assert property (ale_o |-> s.ph == PH_T1 && s.mode)
		else $error("address strobe outside T1");
	a_mid_stable: assert property ((s.ph inside {PH_T2, PH_T3, PH_TW, PH_T4}) |-> $stable(mid_addr_o))
		else $error("middle address moved in cycle");
	a_status_zero: assert property ((s.ph inside {PH_T2, PH_T3, PH_TW, PH_T4}) |-> !high_addr_status_o[3])
		else $error("sixth status bit not zero");
	a_io_top_zero: assert property (t1 && (s.kind inside {K_IORD, K_IOWR}) |-> high_addr_status_o == 4'h0)
		else $error("io cycle top lines not zero");
	a_fetch_seg: assert property (s.ph == PH_T2 && s.kind == K_FETCH |-> high_addr_status_o[1:0] == 2'b10)
		else $error("fetch not reported as code");
	a_flush_qs: assert property (eu_flush_i && !s.mode |=> queue_state_out_o == 2'b10)
		else $error("queue flush status missing");
	a_idle_quiet: assert property (s.ph == PH_TI |-> cycle_type_o == K_PASS && low_addr_data_oe_n_o)
		else $error("idle phase drove a transfer");
endmodule : fbu_top

// ---- testbench.sv ----
// Self-checking bench for the fetch bus unit
`include "fbu_consts.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import fbu_pkg::*;
	logic clock_i = 1'h0, rst_n_i = 1'h0, avs_read_i = 1'h0, avs_write_i = 1'h0, slow = 1'h0;
	logic config_strap_i = 1'h1; // Minimum mode
	logic q_take_i = 1'h0, q_first_i = 1'h0, eu_flush_i = 1'h0, eu_lock_i = 1'h0, halt_req_i = 1'h0;
	logic op_req_i = 1'h0, op_write_i = 1'h0, op_io_i = 1'h0, op_word_i = 1'h0, op_override_i = 1'h0;
	logic vec_req_i = 1'h0, ready_i, low_addr_data_oe_n_o, ale_o, xcvr_enable_n_o, xfer_direction_o;
	logic lock_n_o, q_valid_o, op_ready_o, op_done_o, avs_waitrequest_o;
	logic [4:0] avs_address_i = 5'h00;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
	logic [15:0] eu_jump_cs_i = 16'h0, eu_jump_ip_i = 16'h0, op_offset_i = 16'h0, op_wdata_i = 16'h0;
	logic [15:0] op_rdata_o, cycles, n0;
	logic [7:0] vec_type_i = 8'h00, low_addr_data_i, low_addr_data_o, mid_addr_o, q_byte_o, wbyte, span;
	logic [3:0] high_addr_status_o, stat;
	logic [1:0] queue_state_out_o, rq_gt_o, rq_gt_oe_n_o;
	logic [19:0] addr;
	logic [2:0] kind;
	fbu_class_t op_class_i = SC_DATA;
	fbu_seg_t op_override_seg_i = SEG_DS;
	fbu_kind_t cycle_type_o;
	int error_cnt = 0;
	int check_count = 0;
	fbu_top dut (.clock_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_readdata_o, .avs_waitrequest_o, .config_strap_i, .ready_i, .low_addr_data_i, .low_addr_data_o,
		.low_addr_data_oe_n_o, .mid_addr_o, .high_addr_status_o, .ale_o, .xcvr_enable_n_o, .xfer_direction_o,
		.cycle_type_o, .lock_n_o, .queue_state_out_o, .rq_gt_o, .rq_gt_oe_n_o, .q_byte_o, .q_valid_o, .q_take_i,
		.q_first_i, .eu_flush_i, .eu_jump_cs_i, .eu_jump_ip_i, .eu_lock_i, .halt_req_i, .op_req_i, .op_write_i,
		.op_io_i, .op_word_i, .op_class_i, .op_override_i, .op_override_seg_i, .op_offset_i, .op_wdata_i,
		.vec_req_i, .vec_type_i, .op_ready_o, .op_done_o, .op_rdata_o);
	fbu_mem_model mem (.clock_i, .slow_i(slow), .ale_i(ale_o), .den_n_i(xcvr_enable_n_o), .dir_i(xfer_direction_o),
		.oe_n_i(low_addr_data_oe_n_o), .kind_i(cycle_type_o), .ad_i(low_addr_data_o), .mid_i(mid_addr_o),
		.high_i(high_addr_status_o), .ad_o(low_addr_data_i), .ready_o(ready_i), .addr_o(addr), .kind_o(kind),
		.stat_o(stat), .wbyte_o(wbyte), .span_o(span), .cycles_o(cycles));
	initial begin
		forever #5 clock_i = ~clock_i;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic stop_test();
		if (error_cnt == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic fail();
		chk(32'h0, 32'h1);
		stop_test();
	endtask : fail
	task automatic avs(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clock_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		for (n = 0; n < 20; n++) begin
			@(posedge clock_i);
			if (!avs_waitrequest_o)
				break;
		end
		q = avs_readdata_o;
		avs_read_i <= 1'h0;
		avs_write_i <= 1'h0;
		if (n == 20)
			fail();
	endtask : avs
	task automatic op(input logic v, w, io, wd, input fbu_class_t c, input logic [15:0] off, d);
		int n;
		@(posedge clock_i);
		vec_req_i <= v;
		op_req_i <= !v;
		op_write_i <= w;
		op_io_i <= io;
		op_word_i <= wd;
		op_class_i <= c;
		op_offset_i <= off;
		op_wdata_i <= d;
		vec_type_i <= off[7:0];
		for (n = 0; n < 300; n++) begin
			@(posedge clock_i);
			if (op_ready_o === 1'h1)
				break;
		end
		op_req_i <= 1'h0;
		vec_req_i <= 1'h0;
		for (; n < 300; n++) begin
			@(posedge clock_i);
			if (op_done_o === 1'h1)
				break;
		end
		if (n >= 300)
			fail();
	endtask : op
	task automatic qfull();
		for (int n = 0; n < 30; n++) begin
			avs(1'h0, `FBU_OFF_STAT, 32'h0, rd);
			if (rd[2:0] == 3'h4)
				break;
		end
		chk(32'(rd[2:0]), 32'(`FBU_Q_DEPTH));
	endtask : qfull
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		int n;
		for (n = 0; n < 20 && cycle_type_o === K_PASS; n++)
			@(posedge clock_i);
		chk(32'(cycle_type_o), 32'(K_FETCH));
		chk(32'({high_addr_status_o, mid_addr_o, low_addr_data_o}), 32'h000FFFF0);
		avs(1'h0, `FBU_OFF_CS, 32'h0, rd);
		chk(rd, 32'h0000FFFF);
		avs(1'h0, 5'h1C, 32'h0, rd);
		chk(rd, 32'h0);
	endtask : t_reset
	task automatic t_queue();
		qfull();
		q_take_i <= 1'h1;
		for (int i = 0; i < 4; i++) begin
			@(posedge clock_i);
			chk(32'({q_valid_o, q_byte_o}), 32'h10F - 32'(i));
		end
		q_take_i <= 1'h0;
	endtask : t_queue
	task automatic t_vector();
		op(1'h1, 1'h0, 1'h0, 1'h0, SC_DATA, 16'h0001, 16'h0);
		avs(1'h0, `FBU_OFF_IP, 32'h0, rd);
		chk(rd, 32'h0504);
		avs(1'h0, `FBU_OFF_CS, 32'h0, rd);
		chk(rd, 32'h0706);
	endtask : t_vector
	task automatic t_word();
		qfull();
		avs(1'h1, `FBU_OFF_CTRL, 32'h1, rd);
		avs(1'h1, `FBU_OFF_DS, 32'hFFFF, rd);
		n0 = cycles;
		op(1'h0, 1'h0, 1'h0, 1'h1, SC_DATA, 16'h0011, 16'h0);
		chk(32'(op_rdata_o), 32'h0201);
		chk(32'(cycles - n0), 32'h2);
		chk(32'(addr), 32'h00002);
		chk({kind, stat}, 32'h57);
		chk(32'(span), 32'h4);
	endtask : t_word
	task automatic t_stack();
		avs(1'h1, `FBU_OFF_SS, 32'h1234, rd);
		op(1'h0, 1'h1, 1'h0, 1'h0, SC_STACK, 16'h0010, 16'h005A);
		chk({kind, addr, wbyte}, 32'h61235_05A);
		chk(32'(stat), 32'h5);
	endtask : t_stack
	task automatic t_string();
		avs(1'h1, `FBU_OFF_ES, 32'h0100, rd);
		op_override_i <= 1'h1;
		op(1'h0, 1'h1, 1'h0, 1'h0, SC_STRDST, 16'h0002, 16'h00A5);
		op_override_i <= 1'h0;
		chk({addr, stat}, 32'h010024);
	endtask : t_string
	task automatic t_io();
		op(1'h0, 1'h0, 1'h1, 1'h0, SC_DATA, 16'hABCD, 16'h0);
		chk({kind, addr, op_rdata_o[7:0]}, 32'h10ABCDC6);
		chk(32'(stat), 32'h6);
		op(1'h0, 1'h1, 1'h1, 1'h0, SC_DATA, 16'h0012, 16'h003C);
		chk({kind, addr, wbyte}, 32'h2000123C);
	endtask : t_io
	task automatic t_slow();
		slow <= 1'h1;
		repeat (8) @(posedge clock_i);
		op(1'h0, 1'h0, 1'h0, 1'h1, SC_DATA, 16'h0011, 16'h0);
		chk(32'(op_rdata_o), 32'h0201);
		chk(32'(span > 8'h04), 32'h1);
		slow <= 1'h0;
	endtask : t_slow
	task automatic t_max();
		int n;
		config_strap_i <= 1'h0;
		eu_lock_i <= 1'h1;
		repeat (8) @(posedge clock_i);
		eu_jump_cs_i <= 16'h2000;
		eu_jump_ip_i <= 16'h0030;
		eu_flush_i <= 1'h1;
		@(posedge clock_i);
		eu_flush_i <= 1'h0;
		chk(32'(lock_n_o), 32'h0);
		@(posedge clock_i);
		chk(32'(queue_state_out_o), 32'h2);
		for (n = 0; n < 20 && q_valid_o !== 1'h1; n++)
			@(posedge clock_i);
		chk(32'({q_valid_o, q_byte_o}), 32'h110);
		q_take_i <= 1'h1;
		q_first_i <= 1'h1;
		@(posedge clock_i);
		q_take_i <= 1'h0;
		q_first_i <= 1'h0;
		@(posedge clock_i);
		chk(32'(queue_state_out_o), 32'h1);
		halt_req_i <= 1'h1;
		for (n = 0; n < 30 && cycle_type_o !== K_HALT; n++)
			@(posedge clock_i);
		chk(32'(cycle_type_o), 32'(K_HALT));
		halt_req_i <= 1'h0;
	endtask : t_max
	initial begin
		repeat (4) @(posedge clock_i);
		rst_n_i <= 1'h1;
		t_reset();
		t_queue();
		t_vector();
		t_word();
		t_stack();
		t_string();
		t_io();
		t_slow();
		t_max();
		stop_test();
	end
endmodule : testbench
